// file: hw/ddrh_host.v
// host end of one ddr controller axi4 port, driven from axi4-lite registers
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "ddrh_map.vh"

module ddrh_host (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_awaddr,
	input wire s_awvalid,
	output reg s_awready,
	input wire [31:0] s_wdata,
	input wire [3:0] s_wstrb,
	input wire s_wvalid,
	output reg s_wready,
	output reg [1:0] s_bresp,
	output reg s_bvalid,
	input wire s_bready,
	input wire [7:0] s_araddr,
	input wire s_arvalid,
	output reg s_arready,
	output reg [31:0] s_rdata,
	output reg [1:0] s_rresp,
	output reg s_rvalid,
	input wire s_rready,
	output reg [5:0] awid,
	output reg [32:0] awaddr,
	output reg [7:0] awlen,
	output reg [2:0] awsize,
	output reg [1:0] awburst,
	output reg awlock,
	output reg awqos,
	output reg [3:0] awcache,
	output reg write_auto_precharge_req,
	output reg write_all_bytes_enabled,
	output reg write_coherent_bufferable_sel,
	output reg awvalid,
	input wire awready,
	output reg [511:0] wdata,
	output reg [63:0] wstrb,
	output reg wlast,
	output reg wvalid,
	input wire wready,
	input wire [5:0] bid,
	input wire [1:0] bresp,
	input wire bvalid,
	output reg bready,
	output reg [5:0] arid,
	output reg [32:0] araddr,
	output reg [7:0] arlen,
	output reg [2:0] arsize,
	output reg [1:0] arburst,
	output reg arlock,
	output reg arqos,
	output reg read_auto_precharge_req,
	output reg arvalid,
	input wire arready,
	input wire [511:0] rdata,
	input wire [5:0] rid,
	input wire [1:0] rresp,
	input wire rlast,
	input wire rvalid,
	output reg rready,
	output reg [1:0] interface_clock_select_input
);

localparam W_IDLE = 3'b001;
localparam W_XFER = 3'b010;
localparam W_RESP = 3'b100;
localparam R_IDLE = 2'b01;
localparam R_DATA = 2'b10;

//////////////////////////////////////////////////////////////////////////
// register file
reg [31:0] ctrl_q, attr_q, addr_q, strb_lo_q, strb_hi_q, seed_q, rdat_q, wd_q;
reg [7:0] aw_off_q, wcnt_q, rcnt_q;
reg [3:0] ws_q;
reg [2:0] wst_q;
reg [1:0] rst_q, bres_q, rres_q;
reg aw_held_q, w_held_q, go_w_q, go_r_q, bid_err_q, rid_err_q, rlast_err_q, refuse_q;

wire do_wr = aw_held_q & w_held_q & ~s_bvalid;
wire [31:0] stat = {8'h00, rcnt_q, 6'h00, refuse_q, rlast_err_q, rid_err_q, bid_err_q,
	rres_q, bres_q, ~rst_q[0], ~wst_q[0]};
reg [31:0] rd_mux;
reg hit;
integer k;

always @* begin
	hit = 1'b1;
	case (s_araddr)
		`DDRH_OFF_CTRL: rd_mux = {ctrl_q[31:2], 2'b00};
		`DDRH_OFF_ADDR: rd_mux = addr_q;
		`DDRH_OFF_ATTR: rd_mux = attr_q;
		`DDRH_OFF_STRB_LO: rd_mux = strb_lo_q;
		`DDRH_OFF_STRB_HI: rd_mux = strb_hi_q;
		`DDRH_OFF_SEED: rd_mux = seed_q;
		`DDRH_OFF_STAT: rd_mux = stat;
		`DDRH_OFF_RDAT: rd_mux = rdat_q;
		default: begin
			rd_mux = 32'h0000_0000;
			hit = 1'b0;
		end
	endcase
end

function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0] be;
	begin
		for (k = 0; k < 4; k = k + 1) begin
			merge[k*8 +: 8] = be[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
		end
	end
endfunction

always @(posedge aclk) begin
	if (!aresetn) begin
		s_awready <= 1'b0;
		s_wready <= 1'b0;
		s_bvalid <= 1'b0;
		s_bresp <= `DDRH_RESP_OKAY;
		s_arready <= 1'b0;
		s_rvalid <= 1'b0;
		s_rresp <= `DDRH_RESP_OKAY;
		s_rdata <= 32'h0000_0000;
		aw_held_q <= 1'b0;
		w_held_q <= 1'b0;
		aw_off_q <= 8'h00;
		wd_q <= 32'h0000_0000;
		ws_q <= 4'h0;
		ctrl_q <= `DDRH_CTRL_RST;
		attr_q <= `DDRH_ATTR_RST;
		addr_q <= 32'h0000_0000;
		strb_lo_q <= `DDRH_STRB_RST;
		strb_hi_q <= `DDRH_STRB_RST;
		seed_q <= 32'h0000_0000;
		go_w_q <= 1'b0;
		go_r_q <= 1'b0;
		interface_clock_select_input <= 2'h0;
	end else begin
		go_w_q <= 1'b0;
		go_r_q <= 1'b0;
		s_awready <= ~aw_held_q & ~s_awready & s_awvalid;
		s_wready <= ~w_held_q & ~s_wready & s_wvalid;
		if (s_awvalid & s_awready) begin
			aw_held_q <= 1'b1;
			aw_off_q <= s_awaddr;
		end
		if (s_wvalid & s_wready) begin
			w_held_q <= 1'b1;
			wd_q <= s_wdata;
			ws_q <= s_wstrb;
		end
		if (do_wr) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			s_bvalid <= 1'b1;
			s_bresp <= `DDRH_RESP_OKAY;
			case (aw_off_q)
				`DDRH_OFF_CTRL: begin
					ctrl_q <= merge(ctrl_q, wd_q, ws_q);
					go_w_q <= ws_q[0] & wd_q[`DDRH_CTRL_GO_W];
					go_r_q <= ws_q[0] & wd_q[`DDRH_CTRL_GO_R];
					if (ws_q[3]) interface_clock_select_input <= wd_q[`DDRH_CTRL_CKSEL];
				end
				`DDRH_OFF_ADDR: addr_q <= merge(addr_q, wd_q, ws_q);
				`DDRH_OFF_ATTR: attr_q <= merge(attr_q, wd_q, ws_q);
				`DDRH_OFF_STRB_LO: strb_lo_q <= merge(strb_lo_q, wd_q, ws_q);
				`DDRH_OFF_STRB_HI: strb_hi_q <= merge(strb_hi_q, wd_q, ws_q);
				`DDRH_OFF_SEED: seed_q <= merge(seed_q, wd_q, ws_q);
				`DDRH_OFF_STAT, `DDRH_OFF_RDAT: s_bresp <= `DDRH_RESP_OKAY;
				default: s_bresp <= `DDRH_RESP_SLVERR;
			endcase
		end else if (s_bvalid & s_bready) begin
			s_bvalid <= 1'b0;
		end
		s_arready <= ~s_rvalid & ~s_arready & s_arvalid;
		if (s_arvalid & s_arready) begin
			s_rvalid <= 1'b1;
			s_rdata <= rd_mux;
			s_rresp <= hit ? `DDRH_RESP_OKAY : `DDRH_RESP_SLVERR;
		end else if (s_rvalid & s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
end

//////////////////////////////////////////////////////////////////////////
// write beat payload
wire [7:0] beat_sel = wst_q[0] ? 8'h00 : wcnt_q + 8'h01;
wire [511:0] wdata_d;
genvar g;
generate
	for (g = 0; g < 16; g = g + 1) begin : g_lane
		localparam [31:0] LI = g;
		assign wdata_d[g*32 +: 32] = seed_q + {16'h0000, beat_sel, LI[7:0]};
	end
endgenerate

wire alls = ctrl_q[`DDRH_CTRL_ALLS];
wire [7:0] len = ctrl_q[`DDRH_CTRL_LEN];
wire aw_pend = awvalid & ~awready;
wire w_pend = wvalid & ~(wready & wlast);

//////////////////////////////////////////////////////////////////////////
// write channel master
always @(posedge aclk) begin
	if (!aresetn) begin
		wst_q <= W_IDLE;
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		wlast <= 1'b0;
		bready <= 1'b0;
		wcnt_q <= 8'h00;
		awid <= 6'h00;
		awaddr <= 33'h0_0000_0000;
		awlen <= 8'h00;
		awsize <= 3'h0;
		awburst <= `DDRH_BURST_INCR;
		awlock <= 1'b0;
		awqos <= 1'b0;
		awcache <= 4'h0;
		write_auto_precharge_req <= 1'b0;
		write_all_bytes_enabled <= 1'b0;
		write_coherent_bufferable_sel <= 1'b0;
		wdata <= 512'h0;
		wstrb <= 64'h0;
		bres_q <= `DDRH_RESP_OKAY;
		bid_err_q <= 1'b0;
		refuse_q <= 1'b0;
	end else begin
		case (wst_q)
			W_IDLE: begin
				if (go_w_q) begin
					if (alls && len > `DDRH_ALLS_MAX_LEN) begin
						refuse_q <= 1'b1;
					end else begin
						refuse_q <= 1'b0;
						bid_err_q <= 1'b0;
						awaddr <= {attr_q[`DDRH_ATTR_AHI], addr_q};
						awid <= attr_q[`DDRH_ATTR_ID];
						awlen <= len;
						awsize <= ctrl_q[`DDRH_CTRL_SIZE];
						awburst <= ctrl_q[`DDRH_CTRL_BURST];
						awlock <= ctrl_q[`DDRH_CTRL_LOCK];
						awqos <= ctrl_q[`DDRH_CTRL_QOS];
						awcache <= attr_q[`DDRH_ATTR_CACHE];
						write_coherent_bufferable_sel <= ctrl_q[`DDRH_CTRL_COBUF];
						write_auto_precharge_req <= ctrl_q[`DDRH_CTRL_APC];
						write_all_bytes_enabled <= alls;
						wstrb <= alls ? {64{1'b1}} : {strb_hi_q, strb_lo_q};
						wdata <= wdata_d;
						wlast <= (len == 8'h00);
						wcnt_q <= 8'h00;
						awvalid <= 1'b1;
						wvalid <= 1'b1;
						wst_q <= W_XFER;
					end
				end
			end
			W_XFER: begin
				if (awvalid & awready) awvalid <= 1'b0;
				if (wvalid & wready) begin
					if (wlast) begin
						wvalid <= 1'b0;
						wlast <= 1'b0;
					end else begin
						wcnt_q <= wcnt_q + 8'h01;
						wdata <= wdata_d;
						wlast <= (wcnt_q + 8'h01 == awlen);
					end
				end
				if (!aw_pend && !w_pend) begin
					bready <= 1'b1;
					wst_q <= W_RESP;
				end
			end
			W_RESP: begin
				if (bvalid) begin
					bready <= 1'b0;
					bres_q <= bresp;
					bid_err_q <= (bid != awid);
					wst_q <= W_IDLE;
				end
			end
			default: wst_q <= W_IDLE;
		endcase
	end
end

//////////////////////////////////////////////////////////////////////////
// read channel master
always @(posedge aclk) begin
	if (!aresetn) begin
		rst_q <= R_IDLE;
		arvalid <= 1'b0;
		rready <= 1'b0;
		arid <= 6'h00;
		araddr <= 33'h0_0000_0000;
		arlen <= 8'h00;
		arsize <= 3'h0;
		arburst <= `DDRH_BURST_INCR;
		arlock <= 1'b0;
		arqos <= 1'b0;
		read_auto_precharge_req <= 1'b0;
		rcnt_q <= 8'h00;
		rres_q <= `DDRH_RESP_OKAY;
		rid_err_q <= 1'b0;
		rlast_err_q <= 1'b0;
		rdat_q <= 32'h0000_0000;
	end else begin
		case (rst_q)
			R_IDLE: begin
				if (go_r_q) begin
					araddr <= {attr_q[`DDRH_ATTR_AHI], addr_q};
					arid <= attr_q[`DDRH_ATTR_ID];
					arlen <= len;
					arsize <= ctrl_q[`DDRH_CTRL_SIZE];
					arburst <= ctrl_q[`DDRH_CTRL_BURST];
					arlock <= ctrl_q[`DDRH_CTRL_LOCK];
					arqos <= ctrl_q[`DDRH_CTRL_QOS];
					read_auto_precharge_req <= ctrl_q[`DDRH_CTRL_APC];
					rcnt_q <= 8'h00;
					rres_q <= `DDRH_RESP_OKAY;
					rid_err_q <= 1'b0;
					rlast_err_q <= 1'b0;
					arvalid <= 1'b1;
					rready <= 1'b1;
					rst_q <= R_DATA;
				end
			end
			R_DATA: begin
				if (arvalid & arready) arvalid <= 1'b0;
				if (rvalid & rready) begin
					rcnt_q <= rcnt_q + 8'h01;
					if (rcnt_q == 8'h00) rdat_q <= rdata[31:0];
					if (rresp > rres_q) rres_q <= rresp;
					if (rid != arid) rid_err_q <= 1'b1;
					if (rlast != (rcnt_q == arlen)) rlast_err_q <= 1'b1;
					if (rlast) begin
						rready <= 1'b0;
						rst_q <= R_IDLE;
					end
				end
			end
			default: rst_q <= R_IDLE;
		endcase
	end
end
endmodule // ddrh_host

// file: hw/ddrh_map.vh
// offsets, field positions, reset values and limits of the ddr port host
//////////////////////////////////////////////////////////////////////////
// Contract
// - bvalid and bready both high completes response
// - rvalid and rready both high moves beat
// - host drives 512-bit data, wlast on last
// - 64 byte enables, only enabled bytes stored
// - wvalid and wready both high moves beat
// - host gives 33-bit start address
// - host gives 8-bit length, 3-bit size
// - every request carries 6-bit id
// - request taken when valid and ready high
// - host drives one-bit lock per request
// - host drives qos per request
// - host drives 4-bit cache type on writes
// - all-strobes writes at most 16 beats
// - host drives coherent-bufferable per write
// - phy clock at half data rate
// - controller clock at quarter data rate
// - port on own clock, reset low
//////////////////////////////////////////////////////////////////////////
`ifndef DDRH_MAP_VH
`define DDRH_MAP_VH
`define DDRH_OFF_CTRL 8'h00
`define DDRH_OFF_ADDR 8'h04
`define DDRH_OFF_ATTR 8'h08
`define DDRH_OFF_STRB_LO 8'h0C
`define DDRH_OFF_STRB_HI 8'h10
`define DDRH_OFF_SEED 8'h14
`define DDRH_OFF_STAT 8'h18
`define DDRH_OFF_RDAT 8'h1C
`define DDRH_CTRL_GO_W 0
`define DDRH_CTRL_GO_R 1
`define DDRH_CTRL_APC 2
`define DDRH_CTRL_LOCK 3
`define DDRH_CTRL_QOS 4
`define DDRH_CTRL_ALLS 5
`define DDRH_CTRL_COBUF 6
`define DDRH_CTRL_BURST 9:8
`define DDRH_CTRL_LEN 23:16
`define DDRH_CTRL_SIZE 26:24
`define DDRH_CTRL_CKSEL 29:28
`define DDRH_ATTR_AHI 0
`define DDRH_ATTR_ID 13:8
`define DDRH_ATTR_CACHE 19:16
`define DDRH_CTRL_RST 32'h0601_0100
`define DDRH_ATTR_RST 32'h0000_0000
`define DDRH_STRB_RST 32'hFFFF_FFFF
`define DDRH_BURST_INCR 2'h1
`define DDRH_BURST_WRAP 2'h2
`define DDRH_ALLS_MAX_LEN 8'h0F
`define DDRH_RESP_OKAY 2'h0
`define DDRH_RESP_SLVERR 2'h2
`endif

// file: dv/ddrh_host_chk.sv
// assertions on the controller-side axi4 port of the ddr port host
module ddrh_host_chk (
	input wire aclk, aresetn, awvalid, awready, wvalid, wready, wlast, bvalid, bready,
	input wire arvalid, arready, rvalid, rready, rlast, write_all_bytes_enabled,
	input wire [5:0] awid, arid,
	input wire [32:0] awaddr, araddr,
	input wire [7:0] awlen,
	input wire [1:0] awburst,
	input wire [511:0] wdata
);
	reg [7:0] beat_q;
	reg [7:0] len_q;
	wire [7:0] len_w = awvalid ? awlen : len_q;
	always @(posedge aclk) begin
		if (!aresetn) begin
			beat_q <= 8'h0;
			len_q <= 8'h0;
		end else begin
			if (awvalid) len_q <= awlen;
			if (wvalid && wready) beat_q <= wlast ? 8'h0 : beat_q + 8'h1;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_w_end;
		wvalid && wready && wlast;
	endsequence
	sequence s_aw_done;
		!awvalid || awready;
	endsequence
	chk_aw_hold: assert property (awvalid && !awready |=> awvalid && $stable(awaddr) && $stable(awid))
		else $error("write address moved before taken");
	chk_w_hold: assert property (wvalid && !wready |=> wvalid && $stable(wdata) && $stable(wlast))
		else $error("write beat moved before taken");
	chk_ar_hold: assert property (arvalid && !arready |=> arvalid && $stable(araddr) && $stable(arid))
		else $error("read address moved before taken");
	chk_wlast_pos: assert property (wvalid |-> wlast == (beat_q == len_w))
		else $error("write last on wrong beat");
	chk_alls_len: assert property (awvalid && write_all_bytes_enabled |-> awlen <= 8'h0F)
		else $error("all-strobes burst too long");
	chk_burst_code: assert property (awvalid |-> awburst == 2'h1 || awburst == 2'h2)
		else $error("bad burst code");
	chk_bready_on: assert property (s_w_end ##0 s_aw_done |=> bready)
		else $error("response not awaited");
	chk_bready_off: assert property (bready && bvalid |=> !bready)
		else $error("response ready held");
	chk_rready_keep: assert property (rready && !(rvalid && rlast) |=> rready)
		else $error("read ready dropped early");
	chk_rready_off: assert property (rvalid && rready && rlast |=> !rready)
		else $error("read ready after last");
endmodule // ddrh_host_chk
bind ddrh_host ddrh_host_chk chk (.*);

// file: dv/ddrh_dev_model.sv
// behavioural ddr controller port: one stored word, id echo, optional stalls
module ddrh_dev_model (
	input wire logic aclk, aresetn, slow, bad_id,
	input wire logic [5:0] awid, arid,
	input wire logic [7:0] arlen,
	input wire logic awvalid, wvalid, wlast, arvalid, bready, rready,
	input wire logic [511:0] wdata,
	input wire logic [63:0] wstrb,
	output logic awready, wready, arready, bvalid, rvalid, rlast,
	output logic [5:0] bid, rid,
	output logic [1:0] bresp, rresp,
	output logic [511:0] rdata
);
	logic [511:0] mem_q;
	logic [5:0] wid_q, rid_q;
	logic [7:0] cnt_q;
	logic [1:0] cyc_q = 2'h0;
	// one port, beat address not walked
	// ready follows valid (arready only while rvalid low), every fourth cycle when slow
	assign awready = awvalid && (!slow || cyc_q == 2'h0);
	assign wready = wvalid && (!slow || cyc_q == 2'h0);
	assign arready = arvalid && !rvalid && (!slow || cyc_q == 2'h0);
	// echo ids (bid bit 0 flipped when bad_id), okay status; junk when idle
	assign bid = bvalid ? wid_q ^ {5'h0, bad_id} : ~wid_q;
	assign bresp = bvalid ? 2'h0 : cyc_q;
	assign rid = rvalid ? rid_q : ~rid_q;
	assign rresp = rvalid ? 2'h0 : cyc_q;
	assign rdata = rvalid ? mem_q : ~mem_q;
	assign rlast = rvalid ? cnt_q == 8'h0 : cyc_q[0];
	always @(posedge aclk) begin
		cyc_q <= cyc_q + 2'h1;
		if (!aresetn) begin
			bvalid <= 1'h0;
			rvalid <= 1'h0;
			wid_q <= 6'h0;
			rid_q <= 6'h0;
			cnt_q <= 8'h0;
		end else begin
			if (awvalid && awready) wid_q <= awid;
			if (wvalid && wready) for (int i = 0; i < 64; i++) if (wstrb[i]) mem_q[i*8+:8] <= wdata[i*8+:8];
			if (wvalid && wready && wlast) bvalid <= 1'h1;
			else if (bvalid && bready) bvalid <= 1'h0;
			if (arvalid && arready) begin
				rid_q <= arid;
				cnt_q <= arlen;
				rvalid <= 1'h1;
			end else if (rvalid && rready) begin
				rvalid <= cnt_q != 8'h0;
				cnt_q <= cnt_q - 8'h1;
			end
		end
	end
endmodule // ddrh_dev_model

// file: dv/tb_ddrh_host.sv
// self-checking bench for the ddr port host
module tb_ddrh_host;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic [1:0] r;} ddrh_row_t;
	logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, bad_id = 1'h0;
	logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
	logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'hF;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, awburst, arburst, bresp, rresp, interface_clock_select_input;
	logic [31:0] s_rdata;
	logic [5:0] awid, bid, arid, rid;
	logic [32:0] awaddr, araddr;
	logic [7:0] awlen, arlen;
	logic [2:0] awsize, arsize;
	logic [3:0] awcache;
	logic awlock, awqos, arlock, arqos, write_auto_precharge_req, read_auto_precharge_req;
	logic write_all_bytes_enabled, write_coherent_bufferable_sel;
	logic awvalid, awready, wlast, wvalid, wready, bvalid, bready, arvalid, arready, rlast, rvalid, rready;
	logic [511:0] wdata, rdata;
	logic [63:0] wstrb;
	int error_cnt = 0;
	int compares = 0;
	int cyc = 0;
	logic [31:0] v;
	logic [1:0] rr;
	logic [31:0] ctl [3] = '{32'h0610_0121, 32'h060F_0121, 32'h2603_0201};
	logic [31:0] ref_e [3] = '{32'h200, 32'h0, 32'h0};
	ddrh_row_t rows [7] = '{
		'{8'h00, 1'h0, 32'h0, 32'h0601_0100, 2'h0},
		'{8'h10, 1'h0, 32'h0, 32'hFFFF_FFFF, 2'h0},
		'{8'h04, 1'h1, 32'h1234_5640, 32'h1234_5640, 2'h0},
		'{8'h08, 1'h1, 32'h000F_2A01, 32'h000F_2A01, 2'h0},
		'{8'h14, 1'h1, 32'hA5A5_0000, 32'hA5A5_0000, 2'h0},
		'{8'h18, 1'h1, 32'hFFFF_FFFF, 32'h0, 2'h0},
		'{8'h20, 1'h1, 32'h5A5A_5A5A, 32'h0, 2'h2}
	};
	ddrh_host uut (.*);
	ddrh_dev_model dev (.*);
	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			test_done;
		end
	end
	task automatic test_done;
		$display("compares %0d errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			error_cnt++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'h1;
		s_wvalid <= 1'h1;
		s_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'h0;
			if (s_wready) s_wvalid <= 1'h0;
		end while (!s_bvalid);
		r = s_bresp;
		s_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		s_araddr <= a;
		s_arvalid <= 1'h1;
		s_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'h0;
		end while (!s_rvalid);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic go(input logic [31:0] c, output logic [31:0] s);
		logic [1:0] q;
		wr(8'h00, c, q);
		do rd(8'h18, s, q); while (s[1:0] !== 2'h0);
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d, rr);
				chk({30'h0, rr}, {30'h0, rows[i].r});
			end
			rd(rows[i].a, v, rr);
			chk(v, rows[i].e);
			chk({30'h0, rr}, {30'h0, rows[i].r});
		end
		$display("register table done");
		slow <= 1'h1;
		go(32'h0603_015D, v);
		chk(v & 32'h3FC, 32'h0);
		chk(dev.mem_q[31:0], 32'hA5A5_0300);
		chk(dev.mem_q[511:480], 32'hA5A5_030F);
		chk(awaddr[31:0], 32'h1234_5640);
		chk({3'h0, awaddr[32], awid, awlen, awsize, awburst, awlock, awqos, awcache, write_auto_precharge_req,
			write_coherent_bufferable_sel, write_all_bytes_enabled},
			{3'h0, 1'h1, 6'h2A, 8'h03, 3'h6, 2'h1, 1'h1, 1'h1, 4'hF, 1'h1, 1'h1, 1'h0});
		go(32'h0607_0102, v);
		chk(v & 32'h00FF_03FC, 32'h0008_0000);
		chk(araddr[31:0], 32'h1234_5640);
		chk({9'h0, araddr[32], arid, arlen, arsize, arburst, arlock, arqos, read_auto_precharge_req},
			{9'h0, 1'h1, 6'h2A, 8'h07, 3'h6, 2'h1, 1'h0, 1'h0, 1'h0});
		rd(8'h1C, v, rr);
		chk(v, 32'hA5A5_0300);
		$display("slow bursts done");
		wr(8'h0C, 32'h0000_0003, rr);
		wr(8'h10, 32'h0, rr);
		wr(8'h14, 32'h0000_1234, rr);
		go(32'h0600_0101, v);
		chk(dev.mem_q[31:0], 32'hA5A5_1234);
		bad_id <= 1'h1;
		go(32'h0600_0101, v);
		chk(v & 32'h40, 32'h40);
		bad_id <= 1'h0;
		$display("strobe and id done");
		slow <= 1'h0;
		foreach (ctl[i]) begin
			go(ctl[i], v);
			chk(v & 32'h200, ref_e[i]);
		end
		chk({30'h0, interface_clock_select_input}, 32'h2);
		chk({30'h0, awburst}, 32'h2);
		chk(wstrb[31:0], 32'h0000_0003);
		chk(wstrb[63:32], 32'h0000_0000);
		$display("refusal and clock select done");
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(8'h0C, v, rr);
		chk(v, 32'hFFFF_FFFF);
		chk({30'h0, interface_clock_select_input}, 32'h0);
		$display("second reset done");
		test_done;
	end
endmodule // tb_ddrh_host
